// ### cfg_regs_checker.sv
// Assertion checker for the clock generator configuration bank.
// Sees only the top module ports; bound to the bank below the module.
module cfg_regs_checker
	import clkgen_cfg_pkg::*;
(
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [DATA_W-1:0] pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [DATA_W-1:0] prdata,
	input wire logic              pready,
	input wire logic              pslverr,
	input wire clk_ctrl_t         ctrl
);
	localparam logic [7:0] WAIT_LEN [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
	logic                  lock_wr;

	// Good write to the lock word with its low lane on
	assign lock_wr = psel && penable && pready && pwrite && !pslverr
		&& paddr == 8'h84 && pstrb[0];

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Controls lag the stored word by one edge, so they are judged two edges on
	a_ready_delay: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("pready not two cycles after setup");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready held past one cycle");
	a_read_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("refused read returned data");
	a_wait_decode: assert property (lock_wr |-> ##2
		ctrl.lock_wait_cycles == WAIT_LEN[$past(pwdata[1:0], 2)])
		else $error("lock timer length wrong");
	a_pfd_decode: assert property (lock_wr |-> ##2
		ctrl.pfd_reset_delay == {$past(pwdata[6:5], 2), 2'b10})
		else $error("detector reset delay wrong");
	a_window_en: assert property (lock_wr |-> ##2
		ctrl.lock_window_sel == $past(pwdata[4:2], 2)
		&& ctrl.lock_detect_en == ($past(pwdata[4:2], 2) != 3'h0))
		else $error("lock window or enable wrong");
	a_zero_open: assert property (ctrl.loop_zero_res_open == (ctrl.loop_zero_res_sel == 4'h0))
		else $error("open resistor flag wrong");
	a_source_valid: assert property (ctrl.out1_source_valid == (ctrl.out1_div_source_sel != 2'h2))
		else $error("source valid flag wrong");
	a_div_power: assert property (ctrl.out1_div_powerdown == (ctrl.out1_div_value == 14'h0))
		else $error("divider power-down flag wrong");

	// Main scenarios reached
	c_lock_write: cover property (lock_wr);
	c_refused: cover property (pready && pslverr);
	c_read: cover property (pready && !pwrite && !pslverr);
endmodule

bind clkgen_cfg_regs cfg_regs_checker chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .ctrl(ctrl));

// ### cfg_word.sv
// One 16-bit configuration word with byte-lane writes.
// Assumes the write request is valid only in the cycle the bus completes it.
module cfg_word
	import clkgen_cfg_pkg::*;
#(
	parameter logic [WORD_W-1:0] RESET_VAL = '0
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire word_write_t       wr,
	output logic [WORD_W-1:0]      q
);

	typedef struct packed {
		logic [WORD_W-1:0] word;
	} word_state_t;

	word_state_t state_reg;
	word_state_t state_next;

	// Every bit, reserved ones too, keeps what was written
	always_comb begin
		state_next = state_reg;
		if (wr.en && wr.strb[0]) begin
			state_next.word[7:0] = wr.data[7:0];
		end
		if (wr.en && wr.strb[1]) begin
			state_next.word[15:8] = wr.data[15:8];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{word: RESET_VAL};
		end else begin
			state_reg <= state_next;
		end
	end

	assign q = state_reg.word;

endmodule

// ### clkgen_cfg_pkg.sv
// Constants, field layout and carrier types for the clock generator configuration bank.
// Assumes one register clock and an APB host with 32-bit data and byte addresses.
package clkgen_cfg_pkg;

	// Bus geometry
	localparam int          ADDR_W    = 8;
	localparam int          DATA_W    = 32;
	localparam int          WORD_W    = 16;
	localparam int          NUM_WORDS = 5;

	// Register indices; byte address is four times the index
	localparam logic [5:0]  IDX_LOOP_FILTER  = 6'h1F;
	localparam logic [5:0]  IDX_LOCK_DETECT  = 6'h21;
	localparam logic [5:0]  IDX_OUT1_WORD_A  = 6'h23;
	localparam logic [5:0]  IDX_OUT1_WORD_B  = 6'h24;
	localparam logic [5:0]  IDX_OUT1_DIVIDER = 6'h25;

	// Values after reset
	localparam logic [15:0] RST_LOOP_FILTER  = 16'h1E72;
	localparam logic [15:0] RST_LOCK_DETECT  = 16'h0007;
	localparam logic [15:0] RST_OUT1_WORD_A  = 16'h8000;
	localparam logic [15:0] RST_OUT1_WORD_B  = 16'h0000;
	localparam logic [15:0] RST_OUT1_DIVIDER = 16'h8003;

	// Slot order of the bank, shared by decode and instances
	localparam logic [5:0]  WORD_IDX [NUM_WORDS] = '{IDX_LOOP_FILTER, IDX_LOCK_DETECT,
		IDX_OUT1_WORD_A, IDX_OUT1_WORD_B, IDX_OUT1_DIVIDER};
	localparam logic [15:0] WORD_RST [NUM_WORDS] = '{RST_LOOP_FILTER, RST_LOCK_DETECT,
		RST_OUT1_WORD_A, RST_OUT1_WORD_B, RST_OUT1_DIVIDER};
	localparam int          SLOT_LOOP_FILTER  = 0;
	localparam int          SLOT_LOCK_DETECT  = 1;
	localparam int          SLOT_OUT1_DIVIDER = 4;

	// Field positions
	localparam int          LOCK_WAIT_LSB = 0;
	localparam int          LOCK_WIN_LSB  = 2;
	localparam int          PFD_DLY_LSB   = 5;
	localparam int          ZERO_RES_LSB  = 5;
	localparam int          POLE_CAP_LSB  = 0;
	localparam int          DIV_VAL_LSB   = 0;
	localparam int          DIV_SRC_LSB   = 14;

	// Highest defined loop-filter codes
	localparam logic [3:0]  ZERO_RES_MAX  = 4'hC;
	localparam logic [4:0]  POLE_CAP_MAX  = 5'h14;

	// Lock timer lengths in phase-detector cycles, by code
	localparam logic [7:0]  LOCK_WAIT_C0 = 8'h01;
	localparam logic [7:0]  LOCK_WAIT_C1 = 8'h10;
	localparam logic [7:0]  LOCK_WAIT_C2 = 8'h40;
	localparam logic [7:0]  LOCK_WAIT_C3 = 8'h80;

	// Detector reset delay in detector periods, by code
	localparam logic [3:0]  PFD_DLY_C0 = 4'h2;
	localparam logic [3:0]  PFD_DLY_C1 = 4'h6;
	localparam logic [3:0]  PFD_DLY_C2 = 4'hA;
	localparam logic [3:0]  PFD_DLY_C3 = 4'hE;

	// Divider input sources
	localparam logic [1:0]  SRC_PRESCALER_A = 2'h0;
	localparam logic [1:0]  SRC_PRESCALER_B = 2'h1;
	localparam logic [1:0]  SRC_REFERENCE   = 2'h3;

	// Decoded controls towards the analog PLL, lock timer and output divider
	typedef struct packed {
		logic [7:0]  lock_wait_cycles;
		logic        lock_detect_en;
		logic [2:0]  lock_window_sel;
		logic [3:0]  pfd_reset_delay;
		logic [3:0]  loop_zero_res_sel;
		logic        loop_zero_res_open;
		logic [4:0]  loop_pole_cap_sel;
		logic        loop_code_valid;
		logic [1:0]  out1_div_source_sel;
		logic        out1_source_valid;
		logic [13:0] out1_div_value;
		logic        out1_div_powerdown;
	} clk_ctrl_t;

	localparam clk_ctrl_t CTRL_RST = '{
		lock_wait_cycles:    LOCK_WAIT_C3,
		lock_detect_en:      1'b1,
		lock_window_sel:     3'h1,
		pfd_reset_delay:     PFD_DLY_C0,
		loop_zero_res_sel:   4'h3,
		loop_zero_res_open:  1'b0,
		loop_pole_cap_sel:   5'h12,
		loop_code_valid:     1'b1,
		out1_div_source_sel: 2'h2,
		out1_source_valid:   1'b0,
		out1_div_value:      14'h0003,
		out1_div_powerdown:  1'b0
	};

	// One bus write towards a storage word
	typedef struct packed {
		logic              en;
		logic [1:0]        strb;
		logic [WORD_W-1:0] data;
	} word_write_t;

endpackage

// ### clkgen_cfg_regs.sv
// APB slave holding the PLL lock-detect, loop-filter and first output divider words.
// Assumes an APB4 master on pclk; decoded controls feed analog logic outside.
// Nonvolatile-backed bits behave as plain storage here: no memory image is loaded.
//
// The APB register port was left to the implementer.

module clkgen_cfg_regs
	import clkgen_cfg_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	input  wire logic [3:0]        pstrb,
	output logic [DATA_W-1:0]      prdata,
	output logic                   pready,
	output logic                   pslverr,
	output clk_ctrl_t              ctrl
);

	typedef enum logic [0:0] {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

	typedef struct packed {
		bus_state_t        phase;
		logic              ready;
		logic              err;
		logic [DATA_W-1:0] rdata;
	} slave_state_t;

	slave_state_t state_reg;
	slave_state_t state_next;

	logic [WORD_W-1:0] words [NUM_WORDS];
	word_write_t       wr    [NUM_WORDS];
	logic [NUM_WORDS-1:0] hit;
	logic              complete;
	logic              aligned;

	// One-hot slot select from a byte address; misaligned addresses hit nothing
	function automatic logic [NUM_WORDS-1:0] slot_select(input logic [ADDR_W-1:0] addr);
		logic [NUM_WORDS-1:0] sel;
		sel = '0;
		for (int i = 0; i < NUM_WORDS; i++) begin
			sel[i] = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == WORD_IDX[i]);
		end
		return sel;
	endfunction

	// Read mux over the bank; upper half of the data bus reads zero
	function automatic logic [DATA_W-1:0] read_mux(input logic [NUM_WORDS-1:0] sel,
		input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1,
		input logic [WORD_W-1:0] w2, input logic [WORD_W-1:0] w3,
		input logic [WORD_W-1:0] w4);
		logic [WORD_W-1:0] v;
		v = '0;
		if (sel[0]) v = w0;
		if (sel[1]) v = w1;
		if (sel[2]) v = w2;
		if (sel[3]) v = w3;
		if (sel[4]) v = w4;
		return {{(DATA_W-WORD_W){1'b0}}, v};
	endfunction

	// Address decode and completion strobe
	assign hit      = slot_select(paddr);
	assign aligned  = (paddr[1:0] == 2'b00);
	assign complete = (state_reg.phase == BUS_ANSWER) && psel && penable;

	// Writes land only at the edge where the host sees pready high
	generate
		for (genvar g = 0; g < NUM_WORDS; g++) begin : g_words
			assign wr[g] = '{
				en:   complete && pwrite && hit[g] && !state_reg.err,
				strb: pstrb[1:0],
				data: pwdata[WORD_W-1:0]
			};
			cfg_word #(
				.RESET_VAL (WORD_RST[g])
			) u_word (
				.pclk      (pclk),
				.presetn   (presetn),
				.wr        (wr[g]),
				.q         (words[g])
			);
		end
	endgenerate

	// Bus phase tracking: one wait state, then the answer
	always_comb begin
		state_next = state_reg;
		case (state_reg.phase)
			BUS_IDLE: begin
				state_next.ready = 1'b0;
				if (psel && penable) begin
					// Capture the answer one cycle into the access phase
					state_next.phase = BUS_ANSWER;
					state_next.ready = 1'b1;
					state_next.err   = !aligned || (hit == '0);
					state_next.rdata = pwrite ? '0
						: read_mux(hit, words[0], words[1], words[2], words[3], words[4]);
				end
			end
			BUS_ANSWER: begin
				// Drop ready after the completing edge so no access doubles up
				state_next.phase = BUS_IDLE;
				state_next.ready = 1'b0;
				state_next.err   = 1'b0;
			end
			default: begin
				state_next.phase = BUS_IDLE;
				state_next.ready = 1'b0;
				state_next.err   = 1'b0;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{phase: BUS_IDLE, ready: 1'b0, err: 1'b0, rdata: '0};
		end else begin
			state_reg <= state_next;
		end
	end

	assign prdata  = state_reg.rdata;
	assign pready  = state_reg.ready;
	assign pslverr = state_reg.err;

	// Registered field decode towards the PLL and divider
	ctrl_decode u_decode (
		.pclk      (pclk),
		.presetn   (presetn),
		.loop_word (words[SLOT_LOOP_FILTER]),
		.lock_word (words[SLOT_LOCK_DETECT]),
		.div_word  (words[SLOT_OUT1_DIVIDER]),
		.ctrl      (ctrl)
	);

endmodule

// ### ctrl_decode.sv
// Turns stored codes into registered controls for the analog side.
// Assumes the words come from flops; adds one cycle of latency.
module ctrl_decode
	import clkgen_cfg_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [WORD_W-1:0] loop_word,
	input  wire logic [WORD_W-1:0] lock_word,
	input  wire logic [WORD_W-1:0] div_word,
	output clk_ctrl_t              ctrl
);

	typedef struct packed {
		clk_ctrl_t ctrl;
	} decode_state_t;

	decode_state_t state_reg;
	decode_state_t state_next;

	function automatic logic [7:0] wait_cycles(input logic [1:0] code);
		case (code)
			2'h0:    wait_cycles = LOCK_WAIT_C0;
			2'h1:    wait_cycles = LOCK_WAIT_C1;
			2'h2:    wait_cycles = LOCK_WAIT_C2;
			default: wait_cycles = LOCK_WAIT_C3;
		endcase
	endfunction

	function automatic logic [3:0] pfd_delay(input logic [1:0] code);
		case (code)
			2'h0:    pfd_delay = PFD_DLY_C0;
			2'h1:    pfd_delay = PFD_DLY_C1;
			2'h2:    pfd_delay = PFD_DLY_C2;
			default: pfd_delay = PFD_DLY_C3;
		endcase
	endfunction

	// Field extraction and decode
	always_comb begin
		logic [1:0] src;
		src = div_word[DIV_SRC_LSB +: 2];
		state_next = state_reg;
		state_next.ctrl.lock_wait_cycles   = wait_cycles(lock_word[LOCK_WAIT_LSB +: 2]);
		state_next.ctrl.lock_window_sel    = lock_word[LOCK_WIN_LSB +: 3];
		state_next.ctrl.lock_detect_en     = (lock_word[LOCK_WIN_LSB +: 3] != 3'h0);
		state_next.ctrl.pfd_reset_delay    = pfd_delay(lock_word[PFD_DLY_LSB +: 2]);
		state_next.ctrl.loop_zero_res_sel  = loop_word[ZERO_RES_LSB +: 4];
		state_next.ctrl.loop_zero_res_open = (loop_word[ZERO_RES_LSB +: 4] == 4'h0);
		state_next.ctrl.loop_pole_cap_sel  = loop_word[POLE_CAP_LSB +: 5];
		// Undefined codes are passed on but flagged so firmware faults are visible
		state_next.ctrl.loop_code_valid    = (loop_word[ZERO_RES_LSB +: 4] <= ZERO_RES_MAX)
			&& (loop_word[POLE_CAP_LSB +: 5] <= POLE_CAP_MAX);
		state_next.ctrl.out1_div_source_sel = src;
		state_next.ctrl.out1_source_valid   = (src == SRC_PRESCALER_A)
			|| (src == SRC_PRESCALER_B) || (src == SRC_REFERENCE);
		state_next.ctrl.out1_div_value      = div_word[DIV_VAL_LSB +: 14];
		state_next.ctrl.out1_div_powerdown  = (div_word[DIV_VAL_LSB +: 14] == 14'h0000);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= '{ctrl: CTRL_RST};
		end else begin
			state_reg <= state_next;
		end
	end

	assign ctrl = state_reg.ctrl;

endmodule

// ### pll_lock_and_out1_divider_regs_tb.sv
// Self-checking bench for the configuration bank over APB.
// Assumes the bank answers every transfer itself; a shadow copy predicts reads.
module pll_lock_and_out1_divider_regs_tb
	import clkgen_cfg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [3:0]  pstrb = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	clk_ctrl_t   ctrl;
	logic [31:0] rd_q;
	logic        err_q;
	logic [15:0] m [NUM_WORDS];
	int          n_errors = 0;
	int          checks_done = 0;
	int          cyc = 0;

	always #5 pclk = ~pclk;

	clkgen_cfg_regs dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctrl(ctrl));

	task automatic report_and_stop();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Whole run needs a few hundred cycles
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_errors++;
			report_and_stop();
		end
	end

	task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
		checks_done++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	// One APB transfer; k keeps psel up for a back-to-back setup
	task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d,
		input logic [3:0] s, input logic k);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0, d};
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		// No assumed latency: only the bench timeout ends this wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd_q = prdata;
		err_q = pslverr;
		penable <= 1'b0;
		if (!k) begin
			// An idle edge passes so the next call never re-raises psel in this step
			psel <= 1'b0;
			@(posedge pclk);
		end
	endtask

	// Write a slot and keep the shadow lanes in step
	task automatic wr(input int i, input logic [15:0] d, input logic [3:0] s, input logic k);
		apb(1'b1, {WORD_IDX[i], 2'b00}, d, s, k);
		if (s[0]) m[i][7:0] = d[7:0];
		if (s[1]) m[i][15:8] = d[15:8];
		cmp("write error", 64'h0, 64'(err_q));
	endtask

	task automatic rd(input logic [7:0] a, input logic [15:0] e, input logic ee);
		apb(1'b0, a, 16'h0, 4'h0, 1'b0);
		cmp("read data", 64'(e), 64'(rd_q));
		cmp("read error", 64'(ee), 64'(err_q));
	endtask

	// Expected controls worked out from the shadow words
	function automatic clk_ctrl_t model();
		logic [7:0] wl [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
		clk_ctrl_t  c;
		c.lock_wait_cycles = wl[m[1][1:0]];
		c.lock_detect_en = m[1][4:2] != 3'h0;
		c.lock_window_sel = m[1][4:2];
		c.pfd_reset_delay = {m[1][6:5], 2'b10};
		c.loop_zero_res_sel = m[0][8:5];
		c.loop_zero_res_open = m[0][8:5] == 4'h0;
		c.loop_pole_cap_sel = m[0][4:0];
		c.loop_code_valid = m[0][8:5] <= 4'hC && m[0][4:0] <= 5'h14;
		c.out1_div_source_sel = m[4][15:14];
		c.out1_source_valid = m[4][15:14] != 2'h2;
		c.out1_div_value = m[4][13:0];
		c.out1_div_powerdown = m[4][13:0] == 14'h0;
		return c;
	endfunction

	task automatic check_all();
		for (int i = 0; i < NUM_WORDS; i++) begin
			rd({WORD_IDX[i], 2'b00}, m[i], 1'b0);
		end
		cmp("controls", 64'(model()), 64'(ctrl));
	endtask

	initial begin
		m = '{16'h1E72, 16'h0007, 16'h8000, 16'h0000, 16'h8003};
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		// Reset values first
		check_all();
		// Every bit both ways, back to back
		for (int v = 0; v < 2; v++) begin
			for (int i = 0; i < NUM_WORDS; i++) begin
				wr(i, v ? 16'h0000 : 16'hFFFF, 4'hF, i < NUM_WORDS - 1);
			end
			check_all();
		end
		// All lock timer, detector delay and divider source codes
		for (int c = 0; c < 4; c++) begin
			wr(1, 16'(c * 16'h0025), 4'hF, 1'b1);
			wr(4, {c[1:0], 14'(c)}, 4'hF, 1'b0);
			check_all();
		end
		// Loop filter edges: open and maximum, then undefined codes
		wr(0, 16'h0014, 4'hF, 1'b0);
		check_all();
		wr(0, 16'h01B5, 4'hF, 1'b0);
		check_all();
		// Byte lanes: low lane only, then only unused lanes
		wr(3, 16'hFFFF, 4'h1, 1'b1);
		wr(2, 16'h1234, 4'hC, 1'b0);
		check_all();
		// Unmapped and misaligned places are refused and leave words alone
		apb(1'b1, 8'h88, 16'hFFFF, 4'hF, 1'b0);
		cmp("refused write", 64'h1, 64'(err_q));
		rd(8'h88, 16'h0, 1'b1);
		rd(8'h85, 16'h0, 1'b1);
		check_all();
		report_and_stop();
	end
endmodule
